// file: cpsm_map.vh
`ifndef CPSM_MAP_VH
`define CPSM_MAP_VH
// Profile word layout (per profile)
`define CPSM_M_LSB        0
`define CPSM_M_W          5
`define CPSM_N_LSB        5
`define CPSM_N_W          5
`define CPSM_LF_LSB       10
`define CPSM_LF_W         4
`define CPSM_FBSKEW_LSB   14
`define CPSM_SKEW_W       4
`define CPSM_EXTFB_BIT    18
`define CPSM_PROF_BASE_W  19
// Output enable modes per bank
`define CPSM_OE_ALWAYS    2'h0
`define CPSM_OE_OFF       2'h1
`define CPSM_OE_X         2'h2
`define CPSM_OE_Y         2'h3
// Reset values
`define CPSM_DIV_RESET    6'h00
`define CPSM_PROF_RESET   2'h0
// Power-up internal reset length in cycles
`define CPSM_PWRUP_CYC    8'h10
// Lock: base count of settled cycles required, plus one more per cycle of reset held
`define CPSM_LOCK_BASE    16'h0040
`endif

// file: cpsm_clock_control.v
// Notes on behaviour
// - Coarse mode inserts a divide-by-two before all post-dividers.
// - Coarse unit skew step is twice the fine step, 390ps to 780ps.
// - Four profiles; two select inputs pick profile zero to three.
// - Each profile holds dividers, loop filter, skews and feedback choice.
// - Input, bank, feedback source, skew mode and signature are shared.
// - Power-up generates internal divider and start-up reset automatically.
// - External reset high clears all dividers and drops lock.
// - Relock time grows with how long reset was held.
// - Gate low holds gated outputs at level set by inversion.
// - Secondary enable high keeps assigned outputs high-impedance.
// - Internal feedback from a selected post-divider is an alternative.
// - Gating is synchronous to the internal clock source, chosen per bank.
// - Each driver: always on, off, on first or on second enable.
// - Global disable high forces every driver high-impedance.
`include "cpsm_map.vh"
module cpsm_clock_control #(
  parameter NBANK = 5,
  parameter DW    = 6
) (
  input  wire                          clock_in,
  input  wire                          resetn_in,
  input  wire                          osc_clock_in,
  input  wire                          profile_select_bit0,
  input  wire                          profile_select_bit1,
  input  wire                          ext_reset_in,
  input  wire                          sync_output_gate,
  input  wire                          secondary_enable_x_n,
  input  wire                          secondary_enable_y_n,
  input  wire                          global_output_disable,
  input  wire [4*`CPSM_PROF_BASE_W-1:0] prof_base_in,
  input  wire [4*NBANK*DW-1:0]         prof_vdiv_in,
  input  wire [4*NBANK*4-1:0]          prof_skew_in,
  input  wire                          coarse_mode_in,
  input  wire [2:0]                    fb_bank_sel_in,
  input  wire [NBANK-1:0]              bank_gated_in,
  input  wire [NBANK-1:0]              bank_invert_in,
  input  wire [2*NBANK-1:0]            bank_oe_mode_in,
  input  wire [31:0]                   user_signature_string,
  output reg  [1:0]                    active_profile_out,
  output reg  [`CPSM_PROF_BASE_W-1:0]  active_base_out,
  output reg  [NBANK*4-1:0]            unit_skew_delay,
  output reg                           fb_clock_out,
  output reg                           lock_out,
  output reg  [NBANK-1:0]              bank_clock_out,
  output reg  [NBANK-1:0]              bank_oe_out,
  output reg  [31:0]                   signature_out
);
  // Select, reset, gate, enable, disable and oscillator pins pass two flops before use; only the second stage feeds logic
  reg ps0_s1_q;
  reg ps1_s1_q;
  reg rst1_q;
  reg gate1_q;
  reg oex1_q;
  reg oey1_q;
  reg goe1_q;
  reg osc1_q;
  reg ps0_s2_q;
  reg ps1_s2_q;
  reg rst_s2_q;
  reg gate_s2_q;
  reg oex_s2_q;
  reg oey_s2_q;
  reg goe_s2_q;
  reg osc_s2_q;
  always @(posedge clock_in) begin
    ps0_s1_q <= profile_select_bit0;
    ps1_s1_q <= profile_select_bit1;
    rst1_q   <= ext_reset_in;
    gate1_q  <= sync_output_gate;
    oex1_q   <= secondary_enable_x_n;
    oey1_q   <= secondary_enable_y_n;
    goe1_q   <= global_output_disable;
    osc1_q   <= osc_clock_in;
    ps0_s2_q <= ps0_s1_q;
    ps1_s2_q <= ps1_s1_q;
    rst_s2_q <= rst1_q;
    gate_s2_q <= gate1_q;
    oex_s2_q <= oex1_q;
    oey_s2_q <= oey1_q;
    goe_s2_q <= goe1_q;
    osc_s2_q <= osc1_q;
  end

  // Power-up internal reset
  reg [7:0] pwr_cnt_q;
  wire      pwr_rst = (pwr_cnt_q != `CPSM_PWRUP_CYC);
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      pwr_cnt_q <= 8'h00;
    end else if (pwr_rst) begin
      pwr_cnt_q <= pwr_cnt_q + 8'h01;
    end
  end
  wire div_rst = pwr_rst | rst_s2_q;

  // Profile latch: both bits switch in one edge
  reg [1:0] prof_q;
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      prof_q <= `CPSM_PROF_RESET;
    end else begin
      prof_q <= {ps1_s2_q, ps0_s2_q};
    end
  end

  // Oscillator edge; coarse mode adds a divide-by-two stage
  reg  osc_d1_q, half_q;
  wire osc_rise = osc_s2_q & ~osc_d1_q;
  wire vco_tick = osc_rise & (~coarse_mode_in | half_q);
  always @(posedge clock_in) begin
    if (!resetn_in || div_rst) begin
      osc_d1_q <= 1'b0;
      half_q   <= 1'b0;
    end else begin
      osc_d1_q <= osc_s2_q;
      if (osc_rise) begin
        half_q <= ~half_q;
      end
    end
  end

  // Per-bank post-dividers, toggling outputs, gating and enables
  reg  [NBANK-1:0] div_clk_q;
  genvar b;
  generate
    for (b = 0; b < NBANK; b = b + 1) begin : g_bank
      reg  [DW-1:0] cnt_q;
      wire [DW-1:0] vset = prof_vdiv_in[(prof_q*NBANK+b)*DW +: DW];
      wire [DW-1:0] half = {1'b0, vset[DW-1:1]};
      wire          gate_en;
      wire [1:0]    mode = bank_oe_mode_in[2*b +: 2];
      always @(posedge clock_in) begin
        if (!resetn_in || div_rst) begin
          cnt_q        <= `CPSM_DIV_RESET;
          div_clk_q[b] <= 1'b0;
        end else if (vco_tick) begin
          if (cnt_q + 6'h01 >= (half == 6'h00 ? 6'h01 : half)) begin
            cnt_q        <= `CPSM_DIV_RESET;
            div_clk_q[b] <= ~div_clk_q[b];
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
      end
      // Gate sampled only while divided clock is low, so no runt pulses
      reg gate_q;
      always @(posedge clock_in) begin
        if (!resetn_in) begin
          gate_q <= 1'b0;
        end else if (!div_clk_q[b]) begin
          gate_q <= gate_s2_q;
        end
      end
      assign gate_en = ~bank_gated_in[b] | gate_q;
      always @(posedge clock_in) begin
        if (!resetn_in) begin
          bank_clock_out[b] <= 1'b0;
          bank_oe_out[b]    <= 1'b0;
        end else begin
          bank_clock_out[b] <= (div_clk_q[b] & gate_en) ^ bank_invert_in[b];
          if (goe_s2_q) begin
            bank_oe_out[b] <= 1'b0;
          end else if (mode == `CPSM_OE_ALWAYS) begin
            bank_oe_out[b] <= 1'b1;
          end else if (mode == `CPSM_OE_OFF) begin
            bank_oe_out[b] <= 1'b0;
          end else if (mode == `CPSM_OE_X) begin
            bank_oe_out[b] <= ~oex_s2_q;
          end else begin
            bank_oe_out[b] <= ~oey_s2_q;
          end
        end
      end
    end
  endgenerate

  // Lock model: relock wait grows with reset duration
  reg [15:0] rst_len_q, lock_cnt_q;
  wire [2:0] fbi = (fb_bank_sel_in >= NBANK) ? 3'h0 : fb_bank_sel_in;
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      rst_len_q  <= 16'h0000;
      lock_cnt_q <= 16'h0000;
      lock_out   <= 1'b0;
    end else if (div_rst || goe_s2_q) begin
      lock_out   <= 1'b0;
      lock_cnt_q <= 16'h0000;
      if (rst_len_q != 16'hffff) begin
        rst_len_q <= rst_len_q + 16'h0001;
      end
    end else if (lock_cnt_q >= rst_len_q + `CPSM_LOCK_BASE) begin
      lock_out  <= 1'b1;
      rst_len_q <= 16'h0000;
    end else begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  // Profile-dependent and shared outputs
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      active_profile_out <= 2'h0;
      active_base_out    <= {`CPSM_PROF_BASE_W{1'b0}};
      unit_skew_delay    <= {NBANK*4{1'b0}};
      fb_clock_out       <= 1'b0;
      signature_out      <= 32'h00000000;
    end else begin
      active_profile_out <= prof_q;
      active_base_out    <= prof_base_in[prof_q*`CPSM_PROF_BASE_W +: `CPSM_PROF_BASE_W];
      unit_skew_delay    <= prof_skew_in[prof_q*NBANK*4 +: NBANK*4];
      fb_clock_out       <= div_clk_q[fbi] & ~goe_s2_q;
      signature_out      <= user_signature_string;
    end
  end
endmodule

// file: cpsm_chk.sv
`include "cpsm_map.vh"
module cpsm_chk #(
  parameter NBANK = 5,
  parameter DW    = 6
) (
  input wire                           clock_in,
  input wire                           resetn_in,
  input wire                           profile_select_bit0,
  input wire                           profile_select_bit1,
  input wire                           ext_reset_in,
  input wire                           sync_output_gate,
  input wire                           global_output_disable,
  input wire [4*`CPSM_PROF_BASE_W-1:0] prof_base_in,
  input wire [NBANK-1:0]               bank_gated_in,
  input wire [NBANK-1:0]               bank_invert_in,
  input wire [1:0]                     active_profile_out,
  input wire [`CPSM_PROF_BASE_W-1:0]   active_base_out,
  input wire                           lock_out,
  input wire [NBANK-1:0]               bank_clock_out,
  input wire [NBANK-1:0]               bank_oe_out
);
  wire [1:0] sel = {profile_select_bit1, profile_select_bit0};
  reg  [7:0] quiet_q;
  reg  [7:0] glow_q;
  // Counted at the pins, ahead of the synchronisers, so they bound the design from above
  always @(posedge clock_in) begin
    quiet_q <= (!resetn_in || ext_reset_in || global_output_disable) ? 8'h00 : quiet_q + (quiet_q != 8'hff);
    glow_q  <= (!resetn_in || sync_output_gate) ? 8'h00 : glow_q + (glow_q != 8'hff);
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_disable_forces_hiz: assert property (global_output_disable [*3] |=> bank_oe_out == '0)
    else $error("driver on under global disable");
  a_disable_drops_lock: assert property (global_output_disable [*4] |=> !lock_out)
    else $error("lock kept under global disable");
  a_reset_drops_lock: assert property (ext_reset_in [*4] |=> !lock_out)
    else $error("lock kept under external reset");
  a_lock_after_quiet: assert property ($rose(lock_out) |-> quiet_q >= 8'h40)
    else $error("lock rose too early");
  a_lock_drop_cause: assert property ($fell(lock_out) |-> quiet_q < 8'h05)
    else $error("lock fell without cause");
  a_gate_holds_level: assert property (glow_q > 8'h28 |-> ((bank_clock_out ^ bank_invert_in) & bank_gated_in) == '0)
    else $error("gated bank not parked");
  a_profile_follows: assert property ($stable(sel) [*5] |-> active_profile_out == sel)
    else $error("active profile differs from select");
  a_base_follows: assert property ($stable(sel) [*5] |->
    active_base_out == prof_base_in[sel*`CPSM_PROF_BASE_W +: `CPSM_PROF_BASE_W])
    else $error("profile settings differ from select");
endmodule
bind cpsm_clock_control cpsm_chk #(.NBANK(NBANK), .DW(DW)) u_chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .profile_select_bit0(profile_select_bit0),
  .profile_select_bit1(profile_select_bit1), .ext_reset_in(ext_reset_in), .sync_output_gate(sync_output_gate),
  .global_output_disable(global_output_disable), .prof_base_in(prof_base_in), .bank_gated_in(bank_gated_in),
  .bank_invert_in(bank_invert_in), .active_profile_out(active_profile_out), .active_base_out(active_base_out),
  .lock_out(lock_out), .bank_clock_out(bank_clock_out), .bank_oe_out(bank_oe_out));

// file: cpsm_board.sv
module cpsm_board (
  input  wire       clock_in,
  input  wire       lock_in,
  input  wire [1:0] sel_req_in,
  input  wire       dis_req_in,
  output reg  [1:0] sel_out,
  output reg        ext_reset_out,
  output reg        gate_out,
  output reg        dis_out
);
  timeunit 1ns;
  timeprecision 1ps;
  integer rst_cnt = 0;
  initial {sel_out, ext_reset_out, gate_out, dis_out} = 5'h00;
  always @(negedge clock_in) begin
    rst_cnt <= (sel_req_in != sel_out) ? 4 : (rst_cnt > 0) ? rst_cnt - 1 : 0;
    ext_reset_out <= (rst_cnt > 0) || (sel_req_in != sel_out);
    sel_out <= sel_req_in;
    gate_out <= lock_in;
    // Disable only once locked, else the loop could never lock
    dis_out <= dis_req_in && (lock_in || dis_out);
  end
endmodule

// file: tb.sv
`include "cpsm_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, resetn_in = 0, osc = 0, dis_req = 0, x_n = 1, y_n = 1, coarse = 0;
  logic [1:0] sel_req = 0, ps, prof;
  logic ext_rst, gate, gdis, fb, lock;
  logic [9:0] oe_mode = 10'h000;
  logic [31:0] sig = 32'h5a5a0f0f, sig_o;
  logic [75:0] base;
  logic [79:0] skew;
  logic [119:0] vdiv = {20{6'h02}};
  logic [18:0] act_base;
  logic [19:0] skew_o;
  logic [4:0] bclk, oe;
  int n_errors = 0, n_compared = 0, c;
  initial forever #20 clock_in = ~clock_in;
  initial forever #80 osc = ~osc;
  cpsm_board u_board (.clock_in(clock_in), .lock_in(lock), .sel_req_in(sel_req), .dis_req_in(dis_req),
    .sel_out(ps), .ext_reset_out(ext_rst), .gate_out(gate), .dis_out(gdis));
  cpsm_clock_control DUT (.clock_in(clock_in), .resetn_in(resetn_in), .osc_clock_in(osc),
    .profile_select_bit0(ps[0]), .profile_select_bit1(ps[1]), .ext_reset_in(ext_rst), .sync_output_gate(gate),
    .secondary_enable_x_n(x_n), .secondary_enable_y_n(y_n), .global_output_disable(gdis), .prof_base_in(base),
    .prof_vdiv_in(vdiv), .prof_skew_in(skew), .coarse_mode_in(coarse), .fb_bank_sel_in(3'h0),
    .bank_gated_in(5'h1e), .bank_invert_in(5'h15), .bank_oe_mode_in(oe_mode), .user_signature_string(sig),
    .active_profile_out(prof), .active_base_out(act_base), .unit_skew_delay(skew_o), .fb_clock_out(fb),
    .lock_out(lock), .bank_clock_out(bclk), .bank_oe_out(oe), .signature_out(sig_o));
  task check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task wait_lock;
    c = 0;
    while (lock !== 1'b1) begin
      cyc(1);
      c++;
      if (c > 400) begin
        n_errors++;
        results();
      end
    end
  endtask
  // Counts rising edges of bank 0, gated bank 1 and feedback over 128 cycles; sync jitter allows one either way
  task rate(input logic [5:0] v, input logic m, input int lo, input int hi);
    int nb, nf, ng;
    logic pb, pf, pg;
    vdiv = {20{v}};
    coarse = m;
    cyc(40);
    {nb, nf, ng} = {32'h0, 32'h0, 32'h0};
    {pb, pf, pg} = {bclk[0], fb, bclk[1]};
    repeat (128) begin
      cyc(1);
      nb += bclk[0] & !pb;
      nf += fb & !pf;
      ng += bclk[1] & !pg;
      {pb, pf, pg} = {bclk[0], fb, bclk[1]};
    end
    check(nb >= lo && nb <= hi, 1);
    check(nf >= lo && nf <= hi, 1);
    check(ng >= lo && ng <= hi, 1);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      base[i*19 +: 19] = 19'h0a5c3 + i * 19'h11111;
      skew[i*20 +: 20] = 20'h1b2c4 + i * 20'h21212;
    end
    cyc(20);
    check({prof, oe, lock}, 8'h00);
    resetn_in = 1;
    wait_lock();
    check(c >= 80, 1);
    oe_mode = {`CPSM_OE_Y, `CPSM_OE_X, `CPSM_OE_OFF, `CPSM_OE_ALWAYS, `CPSM_OE_ALWAYS};
    for (int i = 0; i < 4; i++) begin
      {y_n, x_n} = i[1:0];
      cyc(4);
      check(oe, {!y_n, !x_n, 3'b011});
    end
    // Board requests go out by non-blocking write so the board model sees them one falling edge later, free of races
    for (int p = 1; p < 5; p++) begin
      sel_req <= p[1:0];
      cyc(8);
      check({prof, act_base, skew_o}, {p[1:0], base[(p%4)*19 +: 19], skew[(p%4)*20 +: 20]});
      cyc(40);
      check({lock, bclk & 5'h1e}, {1'b0, 5'h14});
      wait_lock();
      check(c >= 16, 1);
    end
    rate(6'h02, 0, 15, 17);
    rate(6'h04, 0, 7, 9);
    rate(6'h02, 1, 7, 9);
    rate(6'h04, 0, 7, 9);
    check(sig_o, sig);
    sig = ~sig;
    cyc(4);
    check(sig_o, sig);
    dis_req <= 1'b1;
    cyc(8);
    check({oe, lock}, 6'h00);
    dis_req <= 1'b0;
    wait_lock();
    check(c >= 64, 1);
    results();
  end
endmodule
